// file: hdl/i2scd_top.sv
// Purpose: Bit and master clock generation and interrupt gating of an audio serial controller
// Assumes: FIFOs, framing and shift logic sit outside and report through the event inputs
// Notes: APB slave with zero wait states; unmapped addresses answer pslverr
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module i2scd_top #(
    parameter int unsigned LVL_W = 4,
    parameter int unsigned DW = 24
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [i2scd_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [LVL_W-1:0] tx_level,
    input wire logic [LVL_W-1:0] rx_level,
    input wire logic tx_overflow_evt,
    input wire logic tx_underflow_evt,
    input wire logic rx_overflow_evt,
    input wire logic rx_fifo_read,
    input wire logic left_valid,
    input wire logic [DW-1:0] left_sample,
    input wire logic right_valid,
    input wire logic [DW-1:0] right_sample,
    input wire logic frame_lrclk,
    input wire logic bclk_i,
    output logic bclk_o,
    output logic bclk_oe,
    input wire logic lrclk_i,
    output logic lrclk_o,
    output logic lrclk_oe,
    output logic bclk_sync,
    output logic lrclk_sync,
    output logic slave_mode,
    output logic mclk_o,
    output logic mclk_oe,
    output logic irq
);
    import i2scd_pkg::*;

    // Sticky flag update; an event in the clearing cycle wins
    function automatic logic flag_next(input logic cur, input logic set, input logic clr);
        return set | (cur & ~clr);
    endfunction

    logic [31:0] mode_reg;
    logic [31:0] clkdiv_reg;
    logic [31:0] ie_reg;
    logic lzcf_reg, rzcf_reg, txovf_reg, txudf_reg, rxovf_reg, rx_underflow_flag_reg;
    logic bclk_s1_reg, lrclk_s1_reg;
    logic lrclk_out_reg;
    logic lzc_pulse, rzc_pulse;
    logic wr_en, rd_setup;
    logic addr_hit;
    logic [31:0] status_word;
    logic [31:0] rd_word;
    logic [31:0] w1c;
    logic [TH_W-1:0] tx_th, rx_th;
    logic [BCLK_DIV_W-1:0] bclk_div;
    logic [MCLK_DIV_W-1:0] mclk_div;
    logic mclk_en;
    logic txthf, rx_threshold_flag;
    logic tx_int, rx_int, zc_int;
    logic [31:0] prdata_reg;
    logic pslverr_reg;

    i2scd_div_if bclk_if ();
    i2scd_div_if mclk_if ();

    assign slave_mode = mode_reg[MODE_SLAVE_BIT];
    assign mclk_en = mode_reg[MODE_MASTER_CLOCK_OUTPUT_ENABLE_BIT];
    assign tx_th = mode_reg[MODE_TX_THRESHOLD_LEVEL_LSB +: TH_W];
    assign rx_th = mode_reg[MODE_RX_THRESHOLD_LEVEL_LSB +: TH_W];
    assign bclk_div = clkdiv_reg[BCLK_DIV_LSB +: BCLK_DIV_W];
    assign mclk_div = clkdiv_reg[MCLK_DIV_LSB +: MCLK_DIV_W];

    // APB access decode
    assign wr_en = psel && penable && pwrite;
    assign rd_setup = psel && !penable;
    assign addr_hit = (paddr == OFS_MODE) || (paddr == OFS_CLKDIV)
        || (paddr == OFS_IE) || (paddr == OFS_STATUS);
    assign w1c = (wr_en && addr_hit && (paddr == OFS_STATUS)) ? pwdata : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= RST_MODE;
        end else if (wr_en && (paddr == OFS_MODE)) begin
            mode_reg <= pwdata & ((32'h0000_0001 << MODE_SLAVE_BIT)
                | (32'h0000_0001 << MODE_MASTER_CLOCK_OUTPUT_ENABLE_BIT)
                | (32'h0000_0007 << MODE_TX_THRESHOLD_LEVEL_LSB) | (32'h0000_0007 << MODE_RX_THRESHOLD_LEVEL_LSB));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clkdiv_reg <= RST_CLKDIV;
        end else if (wr_en && (paddr == OFS_CLKDIV)) begin
            clkdiv_reg <= pwdata & ((32'h0000_00ff << BCLK_DIV_LSB)
                | (32'h0000_0007 << MCLK_DIV_LSB));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ie_reg <= RST_IE;
        end else if (wr_en && (paddr == OFS_IE)) begin
            ie_reg <= pwdata & 32'h0000_1f07;
        end
    end

    // Bit clock divider runs only in master mode
    assign bclk_if.en = !slave_mode;
    assign bclk_if.term = bclk_div;
    i2scd_clkdiv u_bclk_div (
        .pclk(pclk),
        .presetn(presetn),
        .div(bclk_if)
    );

    // Master clock divider; term is divisor minus one for a 2*divisor period
    assign mclk_if.en = mclk_en && (mclk_div != 3'h0);
    assign mclk_if.term = {5'h00, mclk_div - 3'h1};
    i2scd_clkdiv u_mclk_div (
        .pclk(pclk),
        .presetn(presetn),
        .div(mclk_if)
    );

    // Undivided path is a clock mux; divisor changes may clip one pulse
    assign mclk_o = mclk_en && ((mclk_div == 3'h0) ? pclk : mclk_if.clk_level);
    assign mclk_oe = mclk_en;

    // Pin direction follows the mode
    assign bclk_oe = !slave_mode;
    assign lrclk_oe = !slave_mode;
    assign bclk_o = bclk_if.clk_level;
    assign lrclk_o = lrclk_out_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lrclk_out_reg <= 1'b0;
        end else begin
            lrclk_out_reg <= !slave_mode && frame_lrclk;
        end
    end

    // Two-stage synchronisers for the slave clock inputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bclk_s1_reg <= 1'b0;
            bclk_sync <= 1'b0;
            lrclk_s1_reg <= 1'b0;
            lrclk_sync <= 1'b0;
        end else begin
            bclk_s1_reg <= bclk_i;
            bclk_sync <= bclk_s1_reg;
            lrclk_s1_reg <= lrclk_i;
            lrclk_sync <= lrclk_s1_reg;
        end
    end

    i2scd_zcross #(.DW(DW)) u_left_zc (
        .pclk(pclk),
        .presetn(presetn),
        .sample_valid(left_valid),
        .sample(left_sample),
        .zc_pulse(lzc_pulse)
    );

    i2scd_zcross #(.DW(DW)) u_right_zc (
        .pclk(pclk),
        .presetn(presetn),
        .sample_valid(right_valid),
        .sample(right_sample),
        .zc_pulse(rzc_pulse)
    );

    // Level flags follow the FIFO levels directly
    assign txthf = tx_level < {{(LVL_W-TH_W){1'b0}}, tx_th};
    assign rx_threshold_flag = rx_level >= {{(LVL_W-TH_W){1'b0}}, rx_th};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lzcf_reg <= 1'b0;
            rzcf_reg <= 1'b0;
            txovf_reg <= 1'b0;
            txudf_reg <= 1'b0;
            rxovf_reg <= 1'b0;
            rx_underflow_flag_reg <= 1'b0;
        end else begin
            lzcf_reg <= flag_next(lzcf_reg, lzc_pulse, w1c[ST_LZCF_BIT]);
            rzcf_reg <= flag_next(rzcf_reg, rzc_pulse, w1c[ST_RZCF_BIT]);
            txovf_reg <= flag_next(txovf_reg, tx_overflow_evt, w1c[ST_TXOVF_BIT]);
            txudf_reg <= flag_next(txudf_reg, tx_underflow_evt, w1c[ST_TXUDF_BIT]);
            rxovf_reg <= flag_next(rxovf_reg, rx_overflow_evt, w1c[ST_RXOVF_BIT]);
            rx_underflow_flag_reg <= flag_next(rx_underflow_flag_reg, rx_fifo_read && (rx_level == '0),
                w1c[ST_RX_UNDERFLOW_FLAG_BIT]);
        end
    end

    assign zc_int = (lzcf_reg && ie_reg[IE_LZC_BIT])
        || (rzcf_reg && ie_reg[IE_RZC_BIT]);
    assign tx_int = (txthf && ie_reg[IE_TX_THRESHOLD_LEVEL_BIT])
        || (txovf_reg && ie_reg[IE_TXOVF_BIT])
        || (txudf_reg && ie_reg[IE_TXUDF_BIT]);
    assign rx_int = (rx_threshold_flag && ie_reg[IE_RX_THRESHOLD_LEVEL_BIT])
        || (rxovf_reg && ie_reg[IE_RXOVF_BIT])
        || (rx_underflow_flag_reg && ie_reg[IE_RX_UNDERFLOW_FLAG_BIT]);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= zc_int || tx_int || rx_int;
        end
    end

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[ST_TXLVL_LSB +: 4] = 4'(tx_level);
        status_word[ST_RXLVL_LSB +: 4] = 4'(rx_level);
        status_word[ST_LZCF_BIT] = lzcf_reg;
        status_word[ST_RZCF_BIT] = rzcf_reg;
        status_word[ST_TXTHF_BIT] = txthf;
        status_word[ST_TXOVF_BIT] = txovf_reg;
        status_word[ST_TXUDF_BIT] = txudf_reg;
        status_word[ST_RX_THRESHOLD_FLAG_BIT] = rx_threshold_flag;
        status_word[ST_RXOVF_BIT] = rxovf_reg;
        status_word[ST_RX_UNDERFLOW_FLAG_BIT] = rx_underflow_flag_reg;
        status_word[ST_TXINT_BIT] = tx_int;
        status_word[ST_RXINT_BIT] = rx_int;
        status_word[ST_INT_BIT] = irq;
    end

    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (paddr)
            OFS_MODE: rd_word = mode_reg;
            OFS_CLKDIV: rd_word = clkdiv_reg;
            OFS_IE: rd_word = ie_reg;
            OFS_STATUS: rd_word = status_word;
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // Read data and error are captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else if (rd_setup) begin
            prdata_reg <= pwrite ? 32'h0000_0000 : rd_word;
            pslverr_reg <= !addr_hit;
        end
    end

    assign prdata = prdata_reg;
    assign pslverr = psel && penable && pslverr_reg;
    assign pready = 1'b1;

    chk_bclk_slave_idle: assert property (
        @(posedge pclk) disable iff (!presetn)
        slave_mode [*2] |-> !bclk_o && !bclk_oe)
        else $error("bit clock moves in slave mode");
    chk_bclk_toggles: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!slave_mode && bclk_div == 8'h00) [*3] |-> $changed(bclk_o))
        else $error("bit clock not at half source rate with divisor zero");
    chk_mclk_gate: assert property (
        @(posedge pclk) disable iff (!presetn)
        !mclk_en |-> !mclk_o && !mclk_oe)
        else $error("master clock driven while disabled");
    chk_mclk_div_one: assert property (
        @(posedge pclk) disable iff (!presetn)
        (mclk_en && mclk_div == 3'h1) [*3] |-> $changed(mclk_if.clk_level))
        else $error("master clock divisor one not at half source rate");
    chk_pin_dir: assert property (
        @(posedge pclk) disable iff (!presetn)
        bclk_oe == lrclk_oe && (bclk_oe != slave_mode))
        else $error("bit and frame clock directions disagree with mode");
    chk_rx_underflow_flag_set: assert property (
        @(posedge pclk) disable iff (!presetn)
        (rx_fifo_read && rx_level == '0) |=> rx_underflow_flag_reg)
        else $error("empty receive read did not set underflow flag");
    chk_set_wins: assert property (
        @(posedge pclk) disable iff (!presetn)
        (tx_overflow_evt && w1c[ST_TXOVF_BIT]) |=> txovf_reg)
        else $error("overflow event lost to clear");
    chk_lzc_irq: assert property (
        @(posedge pclk) disable iff (!presetn)
        (lzc_pulse && ie_reg[IE_LZC_BIT]) ##1 ie_reg[IE_LZC_BIT] |=> irq)
        else $error("left zero-cross did not interrupt");
    chk_rzc_irq: assert property (
        @(posedge pclk) disable iff (!presetn)
        (rzc_pulse && ie_reg[IE_RZC_BIT]) ##1 ie_reg[IE_RZC_BIT] |=> irq)
        else $error("right zero-cross did not interrupt");
    chk_tx_threshold_level_irq: assert property (
        @(posedge pclk) disable iff (!presetn)
        (tx_level < 4'(tx_th) && ie_reg[IE_TX_THRESHOLD_LEVEL_BIT]) |=> irq)
        else $error("transmit threshold did not interrupt");
    chk_rx_threshold_level_irq: assert property (
        @(posedge pclk) disable iff (!presetn)
        (rx_level >= 4'(rx_th) && ie_reg[IE_RX_THRESHOLD_LEVEL_BIT]) |=> irq)
        else $error("receive threshold did not interrupt");
    chk_rx_flag_irq: assert property (
        @(posedge pclk) disable iff (!presetn)
        ((rx_underflow_flag_reg && ie_reg[IE_RX_UNDERFLOW_FLAG_BIT]) || (rxovf_reg && ie_reg[IE_RXOVF_BIT])) |=> irq)
        else $error("receive flag did not interrupt");
    chk_irq_masked: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ie_reg == 32'h0000_0000) |=> !irq)
        else $error("interrupt with all enables off");
    chk_tx_flag_irq: assert property (
        @(posedge pclk) disable iff (!presetn)
        (txudf_reg && ie_reg[IE_TXUDF_BIT]) |=> irq)
        else $error("transmit underflow did not interrupt");

    cov_master_bclk: cover property (@(posedge pclk) disable iff (!presetn)
        !slave_mode && $rose(bclk_o));
    cov_mclk_div: cover property (@(posedge pclk) disable iff (!presetn)
        mclk_en && mclk_div != 3'h0 && $rose(mclk_if.clk_level));
    cov_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
    cov_w1c: cover property (@(posedge pclk) disable iff (!presetn) $fell(rx_underflow_flag_reg));
endmodule // i2scd_top
`default_nettype wire

// file: hdl/i2scd_pkg.sv
// Purpose: Shared constants of the audio serial clock divider and interrupt enable block
// Assumes: APB register bus, 32-bit data, one aligned word per register
// Notes: Offsets are byte addresses
package i2scd_pkg;
    // Source clock is pclk
    localparam int unsigned SOURCE_CLOCK_FREQUENCY_HZ = 40_000_000;
    localparam int unsigned ADDR_W = 12;
    localparam logic [11:0] OFS_MODE = 12'h000;
    localparam logic [11:0] OFS_CLKDIV = 12'h004;
    localparam logic [11:0] OFS_IE = 12'h008;
    localparam logic [11:0] OFS_STATUS = 12'h00c;
    localparam logic [31:0] RST_MODE = 32'h0000_0000;
    localparam logic [31:0] RST_CLKDIV = 32'h0000_0000;
    localparam logic [31:0] RST_IE = 32'h0000_0000;
    // Mode register fields
    localparam int unsigned MODE_SLAVE_BIT = 8;
    localparam int unsigned MODE_TX_THRESHOLD_LEVEL_LSB = 9;
    localparam int unsigned MODE_RX_THRESHOLD_LEVEL_LSB = 12;
    localparam int unsigned MODE_MASTER_CLOCK_OUTPUT_ENABLE_BIT = 15;
    localparam int unsigned TH_W = 3;
    // Clock divider fields
    localparam int unsigned BCLK_DIV_LSB = 8;
    localparam int unsigned BCLK_DIV_W = 8;
    localparam int unsigned MCLK_DIV_LSB = 0;
    localparam int unsigned MCLK_DIV_W = 3;
    // Interrupt enable fields
    localparam int unsigned IE_LZC_BIT = 12;
    localparam int unsigned IE_RZC_BIT = 11;
    localparam int unsigned IE_TX_THRESHOLD_LEVEL_BIT = 10;
    localparam int unsigned IE_TXOVF_BIT = 9;
    localparam int unsigned IE_TXUDF_BIT = 8;
    localparam int unsigned IE_RX_THRESHOLD_LEVEL_BIT = 2;
    localparam int unsigned IE_RXOVF_BIT = 1;
    localparam int unsigned IE_RX_UNDERFLOW_FLAG_BIT = 0;
    // Status fields
    localparam int unsigned ST_TXLVL_LSB = 28;
    localparam int unsigned ST_RXLVL_LSB = 24;
    localparam int unsigned ST_LZCF_BIT = 23;
    localparam int unsigned ST_RZCF_BIT = 22;
    localparam int unsigned ST_TXTHF_BIT = 18;
    localparam int unsigned ST_TXOVF_BIT = 17;
    localparam int unsigned ST_TXUDF_BIT = 16;
    localparam int unsigned ST_RX_THRESHOLD_FLAG_BIT = 10;
    localparam int unsigned ST_RXOVF_BIT = 9;
    localparam int unsigned ST_RX_UNDERFLOW_FLAG_BIT = 8;
    localparam int unsigned ST_TXINT_BIT = 2;
    localparam int unsigned ST_RXINT_BIT = 1;
    localparam int unsigned ST_INT_BIT = 0;
endpackage

// file: hdl/i2scd_div_if.sv
// Purpose: Control and output of one toggle clock divider
// Assumes: Single pclk domain
// Notes: Divider toggles its level every term+1 cycles
`timescale 1ns/100ps
`default_nettype none
interface i2scd_div_if;
    logic en;
    logic [7:0] term;
    logic clk_level;
    modport ctrl (output en, output term, input clk_level);
    modport gen (input en, input term, output clk_level);
endinterface
`default_nettype wire

// file: hdl/i2scd_clkdiv.sv
// Purpose: Toggle divider producing a clock of period 2*(term+1) source cycles
// Assumes: term may change at any time; the running half period then ends once the count reaches the new term
// Notes: Level and count are held at zero while disabled
`timescale 1ns/100ps
`default_nettype none
module i2scd_clkdiv (
    input wire logic pclk,
    input wire logic presetn,
    i2scd_div_if.gen div
);
    logic [7:0] cnt_reg;
    logic level_reg;
    logic [8:0] half_cnt;
    logic half_ok;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 8'h00;
            level_reg <= 1'b0;
        end else if (!div.en) begin
            cnt_reg <= 8'h00;
            level_reg <= 1'b0;
        end else if (cnt_reg >= div.term) begin
            cnt_reg <= 8'h00;
            level_reg <= ~level_reg;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end

    assign div.clk_level = level_reg;

    // Half period measure, valid only while term and enable held steady
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half_cnt <= 9'h000;
            half_ok <= 1'b0;
        end else if (!div.en || (div.term != $past(div.term))) begin
            half_cnt <= 9'h000;
            half_ok <= 1'b0;
        end else if (cnt_reg >= div.term) begin
            half_cnt <= 9'h001;
            half_ok <= 1'b1;
        end else begin
            half_cnt <= half_cnt + 9'h001;
        end
    end

    chk_div_half_period: assert property (
        @(posedge pclk) disable iff (!presetn)
        (div.en && $stable(div.term) && (cnt_reg >= div.term) && half_ok)
        |-> (half_cnt == {1'b0, div.term} + 9'h001))
        else $error("divider half period differs from term plus one");
endmodule // i2scd_clkdiv
`default_nettype wire

// file: hdl/i2scd_zcross.sv
// Purpose: Zero-cross detector for one audio channel
// Assumes: sample_valid pulses once per new sample of this channel
// Notes: Event when the sign differs from the previous sample or the sample is all zero
`timescale 1ns/100ps
`default_nettype none
module i2scd_zcross #(
    parameter int unsigned DW = 24
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sample_valid,
    input wire logic [DW-1:0] sample,
    output logic zc_pulse
);
    logic prev_sign_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_sign_reg <= 1'b0;
        end else if (sample_valid) begin
            prev_sign_reg <= sample[DW-1];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            zc_pulse <= 1'b0;
        end else begin
            zc_pulse <= sample_valid && ((sample[DW-1] != prev_sign_reg) || (sample == '0));
        end
    end

    chk_zc_zero_sample: assert property (
        @(posedge pclk) disable iff (!presetn)
        (sample_valid && (sample == '0)) |=> zc_pulse)
        else $error("all-zero sample gave no zero-cross event");
    chk_zc_no_sample: assert property (
        @(posedge pclk) disable iff (!presetn)
        !sample_valid |=> !zc_pulse)
        else $error("zero-cross event without a sample");
endmodule // i2scd_zcross
`default_nettype wire

// file: tb/i2scd_codec_model.sv
// Purpose: External audio codec model that drives the serial clocks in slave mode
// Assumes: drive_en is high while the block is a slave
// Notes: A released pin shows a toggling pattern, not a held level
`timescale 1ns/100ps
`default_nettype none
module i2scd_codec_model (
    input wire logic pclk,
    input wire logic drive_en,
    output var logic bclk = 1'b0,
    output var logic lrclk = 1'b0
);
    logic [5:0] cnt_reg = 6'h00;
    always_ff @(posedge pclk) begin
        cnt_reg <= cnt_reg + 6'h01;
        if (drive_en) begin
            bclk <= cnt_reg[1];
            lrclk <= cnt_reg[5];
        end else begin
            bclk <= ~bclk;
            lrclk <= ~lrclk;
        end
    end
endmodule // i2scd_codec_model
`default_nettype wire

// file: tb/i2s_clock_divider_irq_enable_test.sv
// Purpose: Self-checking bench of the clock divider and interrupt enable block
// Assumes: Zero wait state APB slave
// Notes: Event and level inputs are driven at the rising edge
`timescale 1ns/100ps
`default_nettype none
module i2s_clock_divider_irq_enable_test;
    import i2scd_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rdat;
    logic pready, pslverr, serr;
    logic [3:0] tx_level = 4'h8;
    logic [3:0] rx_level = 4'h0;
    logic [3:0] ev = 4'h0;
    logic lv = 1'b0;
    logic fl = 1'b0;
    logic rv = 1'b0;
    logic [23:0] smp = 24'h0;
    logic bclk_o, bclk_oe, lrclk_o, lrclk_oe, bclk_sync, lrclk_sync;
    logic slave_mode, mclk_o, mclk_oe, irq, cod_bclk, cod_lrclk;
    int fail_count = 0;
    int check_count = 0;
    initial forever #12.5 pclk = ~pclk;
    i2scd_top u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tx_level(tx_level), .rx_level(rx_level),
        .tx_overflow_evt(ev[0]), .tx_underflow_evt(ev[1]), .rx_overflow_evt(ev[2]),
        .rx_fifo_read(ev[3]), .left_valid(lv), .left_sample(smp), .right_valid(rv),
        .right_sample(smp), .frame_lrclk(fl), .bclk_i(bclk_oe ? bclk_o : cod_bclk),
        .bclk_o(bclk_o), .bclk_oe(bclk_oe), .lrclk_i(lrclk_oe ? lrclk_o : cod_lrclk),
        .lrclk_o(lrclk_o), .lrclk_oe(lrclk_oe), .bclk_sync(bclk_sync),
        .lrclk_sync(lrclk_sync), .slave_mode(slave_mode), .mclk_o(mclk_o),
        .mclk_oe(mclk_oe), .irq(irq));
    i2scd_codec_model u_codec (.pclk(pclk), .drive_en(slave_mode), .bclk(cod_bclk),
        .lrclk(cod_lrclk));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rdat = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic irq_is(input logic e, input string m);
        check({31'h0, irq}, {31'h0, e}, m);
    endtask
    task automatic half(ref logic s, output int n);
        logic v;
        n = 0;
        @(negedge pclk);
        v = s;
        while (s === v && n < 600) begin
            @(negedge pclk);
            n++;
        end
        v = s;
        n = 0;
        while (s === v && n < 600) begin
            @(negedge pclk);
            n++;
        end
    endtask
    task automatic settle();
        repeat (3) @(posedge pclk);
        @(negedge pclk);
    endtask
    task automatic t_regs();
        rd(OFS_CLKDIV);
        check(rdat, RST_CLKDIV, "divider reset value");
        rd(OFS_IE);
        check(rdat, RST_IE, "enable reset value");
        wr(OFS_CLKDIV, 32'hffff_ffff);
        rd(OFS_CLKDIV);
        check(rdat, 32'h0000_ff07, "divider fields");
        wr(OFS_IE, 32'hffff_ffff);
        rd(OFS_IE);
        check(rdat, 32'h0000_1f07, "enable fields");
        rd(12'h010);
        check({31'h0, serr}, 32'h1, "unmapped error");
        wr(OFS_IE, 32'h0);
    endtask
    task automatic t_clocks();
        int n;
        logic [5:0] seen;
        logic [3:0] hist;
        wr(OFS_CLKDIV, 32'h0000_0203);
        wr(OFS_MODE, 32'h0000_8000);
        half(bclk_o, n);
        check(32'(n), 32'd3, "bit clock half period");
        half(mclk_o, n);
        check(32'(n), 32'd3, "master clock half period");
        check({31'h0, mclk_oe}, 32'h1, "master clock enable");
        wr(OFS_CLKDIV, 32'h0);
        half(bclk_o, n);
        check(32'(n), 32'd1, "bit clock divisor zero");
        @(negedge pclk);
        check({31'h0, mclk_o}, 32'h0, "pass-through low");
        @(posedge pclk);
        #1;
        check({31'h0, mclk_o}, 32'h1, "pass-through high");
        @(posedge pclk);
        fl <= 1'b1;
        settle();
        check({31'h0, lrclk_o & lrclk_oe}, 32'h1, "frame clock driven in master");
        wr(OFS_CLKDIV, 32'h0000_0001);
        wr(OFS_MODE, 32'h0000_0100);
        repeat (4) @(negedge pclk);
        seen = 6'h00;
        repeat (20) @(negedge pclk) seen = seen | {bclk_o, mclk_o, bclk_oe, mclk_oe, lrclk_o, lrclk_oe};
        check({26'h0, seen}, 32'h0, "slave and disabled clocks");
        hist = 4'h0;
        repeat (2) @(negedge pclk) hist = {hist[1:0], cod_bclk, cod_lrclk};
        repeat (8) begin
            @(negedge pclk);
            check({30'h0, bclk_sync, lrclk_sync}, {30'h0, hist[3:2]}, "slave clock sync");
            hist = {hist[1:0], cod_bclk, cod_lrclk};
        end
        wr(OFS_MODE, 32'h0);
        fl <= 1'b0;
    endtask
    task automatic evp(input int i);
        @(posedge pclk);
        ev[i] <= 1'b1;
        @(posedge pclk);
        ev[i] <= 1'b0;
        settle();
    endtask
    task automatic t_events();
        int st[4] = '{ST_TXOVF_BIT, ST_TXUDF_BIT, ST_RXOVF_BIT, ST_RX_UNDERFLOW_FLAG_BIT};
        int ie[4] = '{IE_TXOVF_BIT, IE_TXUDF_BIT, IE_RXOVF_BIT, IE_RX_UNDERFLOW_FLAG_BIT};
        for (int i = 0; i < 4; i++) begin
            evp(i);
            irq_is(1'b0, "masked event");
            rd(OFS_STATUS);
            check({31'h0, rdat[st[i]]}, 32'h1, "sticky event flag");
            wr(OFS_STATUS, 32'h1 << st[i]);
            wr(OFS_IE, 32'h1 << ie[i]);
            evp(i);
            irq_is(1'b1, "enabled event");
            wr(OFS_IE, 32'h0);
            wr(OFS_STATUS, 32'h1 << st[i]);
        end
    endtask
    task automatic lvl(input logic [3:0] t, input logic [3:0] r, input logic e);
        @(posedge pclk);
        tx_level <= t;
        rx_level <= r;
        settle();
        irq_is(e, "threshold interrupt");
    endtask
    task automatic t_thresholds();
        wr(OFS_MODE, 32'h0000_4600);
        wr(OFS_IE, 32'h0000_0404);
        lvl(4'h3, 4'h3, 1'b0);
        lvl(4'h2, 4'h3, 1'b1);
        lvl(4'h3, 4'h4, 1'b1);
        rd(OFS_STATUS);
        check({31'h0, rdat[ST_RX_THRESHOLD_FLAG_BIT]}, 32'h1, "receive threshold flag");
        lvl(4'h8, 4'h0, 1'b0);
        wr(OFS_IE, 32'h0);
        wr(OFS_MODE, 32'h0);
    endtask
    task automatic zc(input int i, input logic [23:0] s);
        @(posedge pclk);
        smp <= s;
        lv <= (i == 0);
        rv <= (i == 1);
        @(posedge pclk);
        lv <= 1'b0;
        rv <= 1'b0;
        repeat (2) @(posedge pclk);
        settle();
    endtask
    task automatic t_zero_cross();
        int fb[2] = '{ST_LZCF_BIT, ST_RZCF_BIT};
        int eb[2] = '{IE_LZC_BIT, IE_RZC_BIT};
        for (int i = 0; i < 2; i++) begin
            zc(i, 24'h000000);
            irq_is(1'b0, "masked zero cross");
            rd(OFS_STATUS);
            check({31'h0, rdat[fb[i]]}, 32'h1, "all zero sample flag");
            wr(OFS_STATUS, 32'h1 << fb[i]);
            wr(OFS_IE, 32'h1 << eb[i]);
            zc(i, 24'h800005);
            irq_is(1'b1, "sign change interrupt");
            wr(OFS_STATUS, 32'h1 << fb[i]);
            zc(i, 24'h800007);
            irq_is(1'b0, "same sign no event");
            wr(OFS_IE, 32'h0);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_clocks();
        t_events();
        t_thresholds();
        t_zero_cross();
        report_and_stop();
    end
    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        report_and_stop();
    end
endmodule // i2s_clock_divider_irq_enable_test
`default_nettype wire
